/* File: rtl/adc_chain.sv */
`timescale 1ns/100ps
// What this block does
// - The output register advances one bit on every falling serial clock edge during readback while chip select is low.
// - Serial output feeds the next device's chain input; bits leave only at the first device.
// - After sync no valid result is flagged until the settling interval has passed.
// - This device's 24-bit word leaves first, then downstream words, MSB first.
// - Results are 24-bit two's complement words sent MSB first.
// - Valid flag falls on a new result, stays low while reading, rises during update.
// - The serial output is released while chip select is high.
// - MSB appears at chip select fall if late, else at the valid flag fall.
module adc_chain
  import adc_pkg::*;
#(
  parameter int W      = RESULT_BITS,
  parameter int SETTLE = SETTLE_MCLKS,
  parameter int HOLD   = HOLD_MCLKS
) (
  // Clock and reset
  input  wire logic         CLK_IN,
  input  wire logic         SRST_IN,
  // Converter pins
  input  wire logic         MCLK_IN,
  input  wire logic         SCLK_IN,
  input  wire logic         CS_N_IN,
  input  wire logic         SYNC_POWERDOWN_N_IN,
  input  wire logic         CHAIN_SERIAL_INPUT_IN,
  // Results from the converter core
  input  wire logic         SAMPLE_VALID_IN,
  input  wire logic [W-1:0] SAMPLE_IN,
  output logic              SAMPLE_READY_OUT,
  // Outputs
  output logic              SERIAL_RESULT_OUTPUT_OUT,
  output logic              SERIAL_RESULT_OUTPUT_OE_OUT,
  output logic              RESULT_VALID_N_OUT
);
  typedef enum logic [1:0] {ST_DOWN = 2'h0, ST_SETTLE = 2'h1, ST_UPDATE = 2'h3, ST_READ = 2'h2}
    adc_state_e;

  // Three-stage pin synchronisers; edges need stages two and three to agree
  logic [2:0] mclk_s;
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [2:0] sync_s;
  logic [2:0] sdi_s;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      mclk_s <= 3'h0;
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      sync_s <= 3'h7;
      sdi_s  <= 3'h0;
    end else begin
      mclk_s <= {mclk_s[1:0], MCLK_IN};
      sclk_s <= {sclk_s[1:0], SCLK_IN};
      cs_s   <= {cs_s[1:0], CS_N_IN};
      sync_s <= {sync_s[1:0], SYNC_POWERDOWN_N_IN};
      sdi_s  <= {sdi_s[1:0], CHAIN_SERIAL_INPUT_IN};
    end
  end

  // Filtered levels; an edge counts once stages two and three agree on the new value
  logic mclk_q;
  logic sclk_q;
  logic cs_q;
  wire  mclk_rise = (mclk_s[2:1] == 2'h3) && !mclk_q;
  wire  sclk_fall = (sclk_s[2:1] == 2'h0) && sclk_q;
  wire  cs_fall   = (cs_s[2:1] == 2'h0) && cs_q;
  wire  cs_rise   = (cs_s[2:1] == 2'h3) && !cs_q;
  wire  sync_lo   = !sync_s[2];
  wire  cs_low    = !cs_q;

  // Sequencing counted on master clock rising edges
  adc_state_e         state;
  adc_state_e         next_state;
  logic [15:0]        cnt;
  logic [W-1:0]       shreg;
  logic               valid_n;
  logic               serial_result_output;
  logic               oe;
  localparam logic [15:0] SETTLE_L = 16'(SETTLE);
  localparam logic [15:0] HOLD_L   = 16'(HOLD);

  adc_word_if #(.W(W)) in_if ();
  adc_word_if #(.W(W)) out_if ();
  assign in_if.valid = SAMPLE_VALID_IN;
  assign in_if.data  = SAMPLE_IN;

  adc_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in  (CLK_IN),
    .srst_in (SRST_IN || sync_lo),
    .wr      (in_if),
    .rd      (out_if)
  );

  // A settled chain with nothing buffered keeps waiting rather than flag an empty word
  wire settle_done = (state == ST_SETTLE) && mclk_rise && (cnt >= SETTLE_L) && out_if.valid;
  wire update_done = (state == ST_UPDATE) && mclk_rise && (cnt >= HOLD_L) && out_if.valid;
  wire load_word   = settle_done || update_done;
  // The window closes on time even when no further word waits; update then stalls
  wire read_end    = (state == ST_READ) && mclk_rise && (cnt >= SETTLE_L);
  assign out_if.ready = load_word;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_DOWN:   if (!sync_lo && mclk_rise) next_state = ST_SETTLE;
      ST_SETTLE: if (settle_done) next_state = ST_READ;
      ST_UPDATE: if (update_done) next_state = ST_READ;
      ST_READ:   if (read_end) next_state = ST_UPDATE;
    endcase
    if (sync_lo) next_state = ST_DOWN;
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      mclk_q <= 1'b0;
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      state  <= ST_DOWN;
      cnt    <= 16'h0000;
    end else begin
      mclk_q <= (mclk_s[2:1] == 2'h3) ? 1'b1 : (mclk_s[2:1] == 2'h0) ? 1'b0 : mclk_q;
      sclk_q <= (sclk_s[2:1] == 2'h3) ? 1'b1 : (sclk_s[2:1] == 2'h0) ? 1'b0 : sclk_q;
      cs_q   <= (cs_s[2:1] == 2'h3) ? 1'b1 : (cs_s[2:1] == 2'h0) ? 1'b0 : cs_q;
      state  <= next_state;
      if (next_state != state) cnt <= 16'h0000;
      else if (mclk_rise && cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
    end
  end

  // Output register; bits from the chain input trail behind this device's word
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      shreg   <= '0;
      valid_n <= 1'b1;
      serial_result_output     <= 1'b0;
      oe      <= 1'b0;
    end else begin
      valid_n <= (next_state != ST_READ);
      oe      <= cs_fall ? 1'b1 : cs_rise ? 1'b0 : oe;
      if (load_word) begin
        shreg <= out_if.data;
        serial_result_output   <= out_if.data[W-1];
      end else if (state == ST_READ && sclk_fall && cs_low) begin
        shreg <= {shreg[W-2:0], sdi_s[2]};
        serial_result_output   <= shreg[W-2];
      end else if (cs_fall) begin
        serial_result_output   <= shreg[W-1];
      end
    end
  end

  assign SERIAL_RESULT_OUTPUT_OUT    = serial_result_output;
  assign SERIAL_RESULT_OUTPUT_OE_OUT = oe;
  assign RESULT_VALID_N_OUT          = valid_n;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) SAMPLE_READY_OUT <= 1'b0;
    else SAMPLE_READY_OUT <= in_if.ready;
  end
endmodule

/* File: rtl/adc_pkg.sv */
package adc_pkg;
  localparam int          RESULT_BITS    = 24;
  localparam int          SETTLE_MCLKS   = 594;
  localparam int          HOLD_MCLKS     = 4;
  localparam int          FIFO_DEPTH     = 4;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
endpackage

/* File: rtl/adc_if.sv */
`timescale 1ns/100ps
interface adc_word_if #(parameter int W = 24);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

/* File: rtl/adc_fifo.sv */
`timescale 1ns/100ps
module adc_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  adc_word_if.dst  wr,
  adc_word_if.src  rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  wire          full  = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
  wire          empty = (wp == rp);
  wire          push  = wr.valid && !full;
  wire          pop   = rd.ready && !empty;
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end
endmodule

/* File: tb/adc_sva.sv */
`timescale 1ns/100ps
module adc_sva (
  input wire logic CLK_IN, SRST_IN, CS_N_IN, SYNC_POWERDOWN_N_IN,
  input wire logic SERIAL_RESULT_OUTPUT_OUT, SERIAL_RESULT_OUTPUT_OE_OUT, RESULT_VALID_N_OUT
);
  wire vn = RESULT_VALID_N_OUT;
  wire oe = SERIAL_RESULT_OUTPUT_OE_OUT;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  property p_oe_off; CS_N_IN [*5] |-> !oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe unselected");
  property p_oe_rise; $rose(oe) |-> !$past(CS_N_IN, 2); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("oe early");
  property p_msb; $fell(vn) && !CS_N_IN && !$past(CS_N_IN, 4) |-> oe; endproperty
  a_msb: assert property (p_msb) else $error("msb undriven");
  property p_sync; !SYNC_POWERDOWN_N_IN [*6] |-> vn; endproperty
  a_sync: assert property (p_sync) else $error("valid in sync");
  property p_settle; $rose(SYNC_POWERDOWN_N_IN) |-> vn [*8]; endproperty
  a_settle: assert property (p_settle) else $error("valid unsettled");
  property p_window; $fell(vn) |-> !vn [*8]; endproperty
  a_window: assert property (p_window) else $error("window short");
  property p_hold; $rose(vn) |-> vn [*8]; endproperty
  a_hold: assert property (p_hold) else $error("update short");
  property p_quiet; vn && $past(vn) |-> $stable(SERIAL_RESULT_OUTPUT_OUT); endproperty
  a_quiet: assert property (p_quiet) else $error("sdo moved");
endmodule
bind adc_chain adc_sva sva_u (.*);

/* File: tb/adc_host.sv */
`timescale 1ns/100ps
module adc_host #(parameter int NB = 48) (
  input  wire logic     valid_n_in,
  input  wire logic     sdo_in,
  output logic          sclk_out,
  output logic [NB-1:0] word_out,
  output logic          done_out
);
  // Clock idles high; 200 ns period fits all bits inside one window
  initial begin
    {sclk_out, done_out, word_out} = {2'b10, NB'(0)};
    forever begin
      @(negedge valid_n_in);
      repeat (NB) begin
        #107 word_out = {word_out[NB-2:0], sdo_in};
        sclk_out = 1'b0;
        #93 sclk_out = 1'b1;
      end
      done_out = !done_out;
    end
  end
endmodule

/* File: tb/tb_adc_daisy_chain_readout.sv */
`timescale 1ns/100ps
module tb_adc_daisy_chain_readout;
  import adc_pkg::*;
  logic CLK_IN = 0, SRST_IN = 1, MCLK_IN = 0, CS_N_IN = 1, SYNC_POWERDOWN_N_IN = 1, SCLK_IN;
  logic SAMPLE_VALID_IN = 0, SAMPLE_READY_OUT, SERIAL_RESULT_OUTPUT_OUT, sdo_b, oe_b, done;
  logic SERIAL_RESULT_OUTPUT_OE_OUT, RESULT_VALID_N_OUT;
  logic [23:0] SAMPLE_IN = 0, sb = 0, qa[4], qb[4];
  logic [47:0] word;
  int seed = 32'h0366, n_mismatch, compares, n;
  wire CHAIN_SERIAL_INPUT_IN = oe_b ? sdo_b : !sdo_b;
  adc_chain #(.SETTLE(120)) dut_u (.*);
  adc_chain #(.SETTLE(120)) dut_u2 (.CLK_IN, .SRST_IN, .MCLK_IN, .SCLK_IN, .CS_N_IN,
    .SYNC_POWERDOWN_N_IN, .CHAIN_SERIAL_INPUT_IN(1'b0), .SAMPLE_VALID_IN, .SAMPLE_IN(sb),
    .SAMPLE_READY_OUT(), .SERIAL_RESULT_OUTPUT_OUT(sdo_b), .SERIAL_RESULT_OUTPUT_OE_OUT(oe_b),
    .RESULT_VALID_N_OUT());
  adc_host host_u (.valid_n_in(RESULT_VALID_N_OUT), .sdo_in(SERIAL_RESULT_OUTPUT_OUT),
    .sclk_out(SCLK_IN), .word_out(word), .done_out(done));
  initial forever #12.5 CLK_IN = !CLK_IN;
  initial forever #50 MCLK_IN = !MCLK_IN;
  function automatic logic [47:0] chain_of(input logic [23:0] a, b);
    return {a, b};
  endfunction
  task automatic chk(input string nm, input logic [47:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #150000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge CLK_IN);
    #1 SRST_IN = 0;
    SYNC_POWERDOWN_N_IN = 0;
    repeat (16) @(posedge CLK_IN);
    #1 SYNC_POWERDOWN_N_IN = 1;
    CS_N_IN = 0;
    repeat (6) @(posedge CLK_IN);
    #1;
    // Push until the buffer refuses; both extremes of the code range go first
    for (n = 0; SAMPLE_READY_OUT === 1'b1; n++) begin
      qa[n % 4] = n ? 24'($random(seed)) : 24'h800000;
      qb[n % 4] = n ? 24'($random(seed)) : 24'h7FFFFF;
      {SAMPLE_IN, sb, SAMPLE_VALID_IN} = {qa[n % 4], qb[n % 4], 1'b1};
      @(posedge CLK_IN);
      #1 SAMPLE_VALID_IN = 0;
      repeat (2) @(posedge CLK_IN);
      #1;
    end
    chk("fill", 48'(FIFO_DEPTH), 48'(n));
    for (n = 0; n < FIFO_DEPTH; n++) begin
      @(done);
      chk("chain", chain_of(qa[n], qb[n]), word);
    end
    $display("test chain done");
    repeat (800) @(posedge CLK_IN);
    chk("idle", 48'(1), 48'(RESULT_VALID_N_OUT));
    $display("test drain done");
    wrap_up();
  end
endmodule
